// ===== core/aes_cipher_pkg.sv
// Shared constants for the memory-mapped block cipher.
package aes_cipher_pkg;

	////////////////////////////////////////////////////////////////////////
	// Byte addresses inside the cipher window.
	localparam logic [7:0] ADDR_STATUS     = 8'h82; // Engine status byte.
	localparam logic [7:0] ADDR_CTRL       = 8'h83; // Control byte.
	localparam logic [7:0] ADDR_PAGE_FIRST = 8'h84; // First page byte.
	localparam logic [7:0] ADDR_PAGE_LAST  = 8'h93; // Last page byte.
	localparam logic [7:0] ADDR_CTRL_COPY  = 8'h94; // Mirror of control.

	////////////////////////////////////////////////////////////////////////
	// Field positions of the control and status bytes.
	localparam int CTRL_REQ_BIT    = 7; // Start request, reads as zero.
	localparam int CTRL_MODE_HI    = 6; // Mode selector, upper bit.
	localparam int CTRL_MODE_LO    = 4; // Mode selector, lower bit.
	localparam int CTRL_DIR_BIT    = 3; // Direction, one means decrypt.
	localparam int STATUS_DONE_BIT = 0; // A run has finished.
	localparam int STATUS_BUSY_BIT = 1; // A run is in progress.

	////////////////////////////////////////////////////////////////////////
	// Mode selector codes and reset values.
	localparam logic [2:0]   MODE_ECB   = 3'h0;
	localparam logic [2:0]   MODE_KEY   = 3'h1;
	localparam logic [2:0]   MODE_CBC   = 3'h2;
	localparam logic         DIR_RST    = 1'b0;
	localparam logic [2:0]   MODE_RST   = 3'h0;
	localparam logic [7:0]   BYTE_RST   = 8'h00;
	localparam logic [127:0] BLOCK_RST  = 128'h0;

	////////////////////////////////////////////////////////////////////////
	// Cipher arithmetic constants.
	localparam logic [3:0] AES_ROUNDS  = 4'hA; // Rounds of a 128-bit key.
	localparam logic [3:0] ROUND_FIRST = 4'h1; // Number of the first round.
	localparam logic [7:0] RCON_FIRST  = 8'h01; // Round constant, round 1.
	localparam logic [7:0] RCON_LAST   = 8'h36; // Round constant, round 10.
	localparam logic [7:0] GF_POLY     = 8'h1B; // Field reduction term.
	localparam logic [7:0] SBOX_AFFINE = 8'h63; // Forward affine constant.
	localparam logic [7:0] INV_AFFINE  = 8'h05; // Inverse affine constant.

	////////////////////////////////////////////////////////////////////////
	// State machine encodings.
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b01,
		ENG_RUN  = 2'b10
	} engine_state_t;

	typedef enum logic [1:0] {
		CTL_IDLE = 2'b01,
		CTL_BUSY = 2'b10
	} ctl_state_t;

endpackage : aes_cipher_pkg

// ===== core/aes128_round_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Iterative cipher core, one round per clock.
module aes128_round_engine
	import aes_cipher_pkg::*;
(
	// Clock and reset.
	input  wire  logic         clk,
	input  wire  logic         sys_rst,
	// Run control.
	input  wire  logic         start,
	input  wire  logic         abort,
	input  wire  logic         decrypt,
	input  wire  logic [127:0] key_in,
	input  wire  logic [127:0] blk_in,
	// Results.
	output logic               busy,
	output logic               done,
	output logic [127:0]       blk_out,
	output logic [127:0]       round_key_out
);

	////////////////////////////////////////////////////////////////////////
	// Field arithmetic.
	function automatic logic [7:0] xtime(input logic [7:0] b);
		return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : BYTE_RST);
	endfunction : xtime

	function automatic logic [7:0] gmul(input logic [7:0] a,
	                                    input logic [7:0] b);
		logic [7:0] acc;
		logic [7:0] p;
		acc = BYTE_RST;
		p = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				acc = acc ^ p;
			p = xtime(p);
		end
		return acc;
	endfunction : gmul

	// The inverse is a to the power 254; zero maps to zero.
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] sq;
		r = 8'h01;
		sq = gmul(a, a);
		for (int k = 1; k < 8; k++)
		begin
			r = gmul(r, sq);
			sq = gmul(sq, sq);
		end
		return r;
	endfunction : ginv

	function automatic logic [7:0] rol(input logic [7:0] b, input int n);
		logic [15:0] t;
		t = {b, b} << n;
		return t[15:8];
	endfunction : rol

	// Substitution tables are computed, trading area for no stored tables.
	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] b;
		b = ginv(a);
		return b ^ rol(b, 1) ^ rol(b, 2) ^ rol(b, 3) ^ rol(b, 4) ^ SBOX_AFFINE;
	endfunction : sbox

	function automatic logic [7:0] inv_sbox(input logic [7:0] s);
		return ginv(rol(s, 1) ^ rol(s, 3) ^ rol(s, 6) ^ INV_AFFINE);
	endfunction : inv_sbox

	////////////////////////////////////////////////////////////////////////
	// Round transforms; byte 0 sits in the top eight bits, column major.
	function automatic logic [127:0] sub_shift(input logic [127:0] s,
	                                           input logic inv);
		logic [127:0] o;
		logic [7:0]   b;
		int           src;
		o = BLOCK_RST;
		for (int i = 0; i < 16; i++)
		begin
			src = inv ? 4 * (((i / 4) + 4 - (i % 4)) % 4) + (i % 4)
			          : 4 * (((i / 4) + (i % 4)) % 4) + (i % 4);
			b = s[127 - 8 * src -: 8];
			o[127 - 8 * i -: 8] = inv ? inv_sbox(b) : sbox(b);
		end
		return o;
	endfunction : sub_shift

	function automatic logic [127:0] mix(input logic [127:0] s,
	                                     input logic inv);
		logic [127:0] o;
		logic [31:0]  m;
		logic [7:0]   acc;
		o = BLOCK_RST;
		m = inv ? 32'h0E0B0D09 : 32'h02030101;
		for (int c = 0; c < 4; c++)
		begin
			for (int r = 0; r < 4; r++)
			begin
				acc = BYTE_RST;
				for (int k = 0; k < 4; k++)
					acc = acc ^ gmul(s[127 - 8 * (4 * c + (r + k) % 4) -: 8],
					                 m[31 - 8 * k -: 8]);
				o[127 - 8 * (4 * c + r) -: 8] = acc;
			end
		end
		return o;
	endfunction : mix

	function automatic logic [31:0] sub_rot(input logic [31:0] w,
	                                        input logic [7:0] rc);
		return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]),
		        sbox(w[31:24])};
	endfunction : sub_rot

	////////////////////////////////////////////////////////////////////////
	// Round registers.
	engine_state_t state_q;      // Engine state.
	logic [127:0]  blk_q;        // Cipher state, result once done.
	logic [127:0]  key_q;        // Current round key.
	logic [7:0]    rcon_q;       // Round constant of the next step.
	logic [3:0]    round_q;      // Number of the next round.
	logic          done_q;       // One-cycle completion pulse.

	// Next round keys, forward for encryption and backward for decryption.
	wire  logic [31:0]  kf0 = key_q[127:96] ^ sub_rot(key_q[31:0], rcon_q);
	wire  logic [31:0]  kf1 = key_q[95:64] ^ kf0;
	wire  logic [31:0]  kf2 = key_q[63:32] ^ kf1;
	wire  logic [31:0]  kf3 = key_q[31:0] ^ kf2;
	wire  logic [31:0]  kb3 = key_q[31:0] ^ key_q[63:32];
	wire  logic [31:0]  kb2 = key_q[63:32] ^ key_q[95:64];
	wire  logic [31:0]  kb1 = key_q[95:64] ^ key_q[127:96];
	wire  logic [31:0]  kb0 = key_q[127:96] ^ sub_rot(kb3, rcon_q);
	wire  logic         last_round = (round_q == AES_ROUNDS);
	wire  logic         dir_q;   // Direction held for the whole run.
	logic               dir_r;
	assign dir_q = dir_r;
	wire  logic [127:0] key_d = dir_q ? {kb0, kb1, kb2, kb3}
	                                  : {kf0, kf1, kf2, kf3};
	wire  logic [127:0] ss_d = sub_shift(blk_q, dir_q);
	// Encrypt mixes before the key add, decrypt after adding it.
	wire  logic [127:0] enc_d = (last_round ? ss_d : mix(ss_d, 1'b0)) ^ key_d;
	wire  logic [127:0] dec_d = last_round ? (ss_d ^ key_d)
	                                       : mix(ss_d ^ key_d, 1'b1);
	wire  logic [7:0]   rcon_d = dir_q
		? (rcon_q[0] ? (((rcon_q ^ GF_POLY) >> 1) | 8'h80) : (rcon_q >> 1))
		: xtime(rcon_q);

	// Abort wipes the working copy so no partial data lingers.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ENG_IDLE;
			blk_q   <= BLOCK_RST;
			key_q   <= BLOCK_RST;
			rcon_q  <= RCON_FIRST;
			round_q <= ROUND_FIRST;
			done_q  <= 1'b0;
			dir_r   <= DIR_RST;
		end
		else if (abort)
		begin
			state_q <= ENG_IDLE;
			blk_q   <= BLOCK_RST;
			key_q   <= BLOCK_RST;
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			unique case (state_q)
				ENG_IDLE:
				begin
					// The first key add uses the key as given.
					if (start)
					begin
						state_q <= ENG_RUN;
						blk_q   <= blk_in ^ key_in;
						key_q   <= key_in;
						dir_r   <= decrypt;
						rcon_q  <= decrypt ? RCON_LAST : RCON_FIRST;
						round_q <= ROUND_FIRST;
					end
				end
				ENG_RUN:
				begin
					blk_q   <= dir_q ? dec_d : enc_d;
					key_q   <= key_d;
					rcon_q  <= rcon_d;
					round_q <= round_q + 4'h1;
					if (last_round)
					begin
						state_q <= ENG_IDLE;
						done_q  <= 1'b1;
					end
				end
				default:
				begin
					state_q <= ENG_IDLE;
				end
			endcase
		end
	end

	assign busy          = (state_q == ENG_RUN);
	assign done          = done_q;
	assign blk_out       = blk_q;
	assign round_key_out = key_q;

endmodule : aes128_round_engine
`default_nettype wire

// ===== core/aes128_block_cipher_control.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - AES core, 128-bit key and block.
// - Cipher runs independently of radio activity.
// - Everything reached through window 0x82 to 0x94.
// - Fast access: write new, read old together.
// - Initial key kept apart, never modified.
// - Key and data pages share addresses.
// - Key page reads give last round key.
// - Stored initial key used for next run.
// - Mode zero runs ECB on data page.
// - Direction bit selects encrypt or decrypt.
// - Request bit at control or mirror starts.
// - One access configures, loads and starts.
// - No access while asleep or in reset.
// - Power-down or reset clears everything.
// - Control byte access while running aborts.
// - Mode two chains previous result in.
// - Direction zero encrypts, one decrypts.
module aes128_block_cipher_control
	import aes_cipher_pkg::*;
#(
	parameter int unsigned PAGE_BYTES = 16 // Bytes in each page.
)
(
	// Clock and reset.
	input  wire  logic       clk,
	input  wire  logic       sys_rst,
	// Transceiver power states, from logic on the same clock.
	input  wire  logic       trx_sleep,
	input  wire  logic       deepest_power_down,
	input  wire  logic       trx_reset_state,
	// Memory-style byte access.
	input  wire  logic [7:0] mem_addr,
	input  wire  logic       mem_wr,
	input  wire  logic       mem_rd,
	input  wire  logic [7:0] mem_wdata,
	output logic [7:0]       mem_rdata,
	output logic             mem_ack,
	// Engine status.
	output logic             cipher_busy,
	output logic             cipher_done
);

	////////////////////////////////////////////////////////////////////////
	// Parameter check.
	if (PAGE_BYTES != 16)
	begin : g_bad_page
		$error("PAGE_BYTES must be 16 for a 128-bit block");
	end

	////////////////////////////////////////////////////////////////////////
	// Address decoding helpers, used for both reads and writes.
	function automatic logic in_window(input logic [7:0] a);
		return (a >= ADDR_STATUS) && (a <= ADDR_CTRL_COPY);
	endfunction : in_window

	function automatic logic in_page(input logic [7:0] a);
		return (a >= ADDR_PAGE_FIRST) && (a <= ADDR_PAGE_LAST);
	endfunction : in_page

	function automatic logic [3:0] page_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_PAGE_FIRST;
		return d[3:0];
	endfunction : page_index

	////////////////////////////////////////////////////////////////////////
	// Registers.
	ctl_state_t   state_q;                  // Control state.
	logic [2:0]   mode_q;                   // Mode selector.
	logic         dir_q;                    // Direction bit.
	logic         busy_q;                   // Busy flag to the pins.
	logic         done_q;                   // Sticky completion flag.
	logic [7:0]   rdata_q;                  // Byte returned by an access.
	logic         ack_q;                    // Access taken pulse.

	// Result and key storage.
	logic [127:0] prev_q;                   // Last result, for chaining.
	logic [127:0] last_key_q;               // Last round key of last run.
	logic [7:0]   data_q [PAGE_BYTES];      // Data page.
	logic [7:0]   init_key_q [PAGE_BYTES];  // Initial key store.

	////////////////////////////////////////////////////////////////////////
	// Access qualification.
	// Sleep and the reset-like states shut the window entirely.
	wire logic blocked   = trx_sleep | deepest_power_down
	                     | trx_reset_state;

	// Reset-like states wipe configuration, data and keys.
	wire logic clear_all = deepest_power_down | trx_reset_state;

	// Only window addresses answer, nothing else is needed.
	wire logic win_hit   = in_window(mem_addr);
	// A write wins when both strobes are up in one cycle.
	wire logic taken_wr  = mem_wr & ~blocked & win_hit;
	wire logic taken_rd  = mem_rd & ~mem_wr & ~blocked & win_hit;
	wire logic taken     = taken_wr | taken_rd;

	wire logic page_hit  = in_page(mem_addr);
	wire logic [3:0] idx = page_index(mem_addr);

	// The mirror byte never aborts a run.
	wire logic ctrl_hit  = taken & (mem_addr == ADDR_CTRL);
	wire logic ctrl_wr   = taken_wr & ((mem_addr == ADDR_CTRL)
	                     | (mem_addr == ADDR_CTRL_COPY));
	wire logic [2:0] wr_mode = mem_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
	wire logic running   = (state_q == CTL_BUSY);

	// Any touch of the control byte mid-run ends the run.
	wire logic abort_run = ctrl_hit & running;

	// Only ECB and CBC may start; key mode and spare codes cannot.
	wire logic mode_ok   = (wr_mode == MODE_ECB)
	                     | (wr_mode == MODE_CBC);

	// The mirror byte ends a combined access and fires the run.
	wire logic start_run = ctrl_wr & mem_wdata[CTRL_REQ_BIT] & mode_ok
	                     & ~running & ~clear_all;

	////////////////////////////////////////////////////////////////////////
	// Engine hookup.
	wire logic [127:0] data_flat;
	wire logic [127:0] key_flat;
	wire logic [127:0] eng_out;
	wire logic [127:0] eng_rkey;
	wire logic         eng_done;

	// Chaining folds the previous result into the new block.
	wire logic [127:0] eng_in = (wr_mode == MODE_CBC)
	                          ? (data_flat ^ prev_q) : data_flat;

	// Direction zero encrypts, one decrypts.
	wire logic eng_decrypt = mem_wdata[CTRL_DIR_BIT];

	// An abort in the completion cycle throws the result away.
	wire logic eng_fin = eng_done & ~abort_run;

	// The engine has no link to the radio, so it runs during frames.
	aes128_round_engine u_engine (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.start         (start_run),
		.abort         (abort_run | clear_all),
		.decrypt       (eng_decrypt),
		.key_in        (key_flat),
		.blk_in        (eng_in),
		.busy          (),
		.done          (eng_done),
		.blk_out       (eng_out),
		.round_key_out (eng_rkey)
	);

	////////////////////////////////////////////////////////////////////////
	// Page storage; one generate slice per byte.
	for (genvar i = 0; i < PAGE_BYTES; i++)
	begin : g_page
		// Mode picks which page a page address lands in.
		wire logic key_wr  = taken_wr & page_hit & (idx == 4'(i))
		                   & (mode_q == MODE_KEY);
		wire logic data_wr = taken_wr & page_hit & (idx == 4'(i))
		                   & (mode_q != MODE_KEY);

		// A host write lands on top of a result finishing the same cycle.
		wire logic [7:0] data_d = data_wr ? mem_wdata
		                        : (eng_fin  ? eng_out[127 - 8 * i -: 8]
		                                    : data_q[i]);

		wire logic [7:0] key_d  = key_wr ? mem_wdata : init_key_q[i];

		assign data_flat[127 - 8 * i -: 8] = data_q[i];
		assign key_flat[127 - 8 * i -: 8]  = init_key_q[i];

		// The initial key changes only by a host write or a reset-like wipe, never by a run.
		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				data_q[i]     <= BYTE_RST;
				init_key_q[i] <= BYTE_RST;
			end
			else if (clear_all)
			begin
				data_q[i]     <= BYTE_RST;
				init_key_q[i] <= BYTE_RST;
			end
			else
			begin
				data_q[i]     <= data_d;
				init_key_q[i] <= key_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data selection.
	// Busy sits in bit one and done in bit zero.
	wire logic [7:0] status_byte = {6'h00, running, done_q};

	// The request bit does not hold, so it reads back as zero.
	wire logic [7:0] ctrl_byte   = {1'b0, mode_q, dir_q, 3'h0};

	// Key page shows the last round key, not the stored key.
	wire logic [7:0] page_byte   = (mode_q == MODE_KEY)
	                             ? last_key_q[127 - 8 * idx -: 8]
	                             : data_q[idx];

	// Both control addresses read the same byte.
	wire logic [7:0] rd_byte     = (mem_addr == ADDR_STATUS) ? status_byte
	                             : page_hit ? page_byte
	                             : ctrl_byte;

	////////////////////////////////////////////////////////////////////////
	// Control state and configuration.
	wire ctl_state_t state_d = (clear_all | abort_run | eng_done) ? CTL_IDLE
	                         : start_run ? CTL_BUSY : state_q;

	// Mode and direction follow every control or mirror write.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= CTL_IDLE;
			mode_q  <= MODE_RST;
			dir_q   <= DIR_RST;
			busy_q  <= 1'b0;
		end
		else if (clear_all)
		begin
			state_q <= CTL_IDLE;
			mode_q  <= MODE_RST;
			dir_q   <= DIR_RST;
			busy_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			busy_q  <= (state_d == CTL_BUSY);
			if (ctrl_wr)
			begin
				mode_q <= wr_mode;
				dir_q  <= mem_wdata[CTRL_DIR_BIT];
			end
		end
	end

	// Results, done flag and round key are captured at completion.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			done_q     <= 1'b0;
			prev_q     <= BLOCK_RST;
			last_key_q <= BLOCK_RST;
		end
		else if (clear_all)
		begin
			done_q     <= 1'b0;
			prev_q     <= BLOCK_RST;
			last_key_q <= BLOCK_RST;
		end
		else if (eng_fin)
		begin
			// A start cannot coincide with completion.
			done_q     <= 1'b1;
			prev_q     <= eng_out;
			last_key_q <= eng_rkey;
		end
		else if (start_run | abort_run)
		begin
			done_q <= 1'b0;
		end
	end

	// Every access returns the byte held before it, so a write shifts
	// the old result out while the new input goes in.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdata_q <= BYTE_RST;
			ack_q   <= 1'b0;
		end
		else
		begin
			ack_q <= taken;
			if (taken)
				rdata_q <= rd_byte;
		end
	end

	assign mem_rdata   = rdata_q;
	assign mem_ack     = ack_q;
	assign cipher_busy = busy_q;
	assign cipher_done = done_q;

endmodule : aes128_block_cipher_control
`default_nettype wire

// ===== testbench/aes128_cipher_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aes128_cipher_chk
	import aes_cipher_pkg::*;
#(
	parameter int unsigned PAGE_BYTES = 16 // Bytes in each page.
)
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       sys_rst,
	// Power states.
	input wire logic       trx_sleep,
	input wire logic       deepest_power_down,
	input wire logic       trx_reset_state,
	// Byte access.
	input wire logic [7:0] mem_addr,
	input wire logic       mem_wr,
	input wire logic       mem_rd,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic       mem_ack,
	// Engine status.
	input wire logic       cipher_busy,
	input wire logic       cipher_done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// Any low-power or reset state blocks the window.
	wire logic       blk  = trx_sleep | deepest_power_down | trx_reset_state;
	// An access is taken only inside the window and while awake.
	wire logic       take = (mem_wr | mem_rd) & !blk
		& (mem_addr >= ADDR_STATUS) & (mem_addr <= ADDR_CTRL_COPY);
	wire logic       ctl  = take & (mem_addr == ADDR_CTRL);
	wire logic [2:0] mode = mem_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
	// Only the two cipher modes may launch a run, and only when idle.
	wire logic       go   = take & mem_wr & mem_wdata[CTRL_REQ_BIT]
		& (mode == MODE_ECB | mode == MODE_CBC) & !cipher_busy
		& (mem_addr == ADDR_CTRL | mem_addr == ADDR_CTRL_COPY);
	logic [3:0] run_q; // Consecutive busy cycles seen.
	logic [3:0] run_d;
	assign run_d = cipher_busy ? run_q + 4'h1 : 4'h0;

	// Counting busy cycles lets a short assertion bound a long run.
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			run_q <= 4'h0;
		else
			run_q <= run_d;

	////////////////////////////////////////////////////////////////////////
	ack_on_take_a: assert property (take |=> mem_ack)
		else $error("taken access not acknowledged");
	refuse_quiet_a: assert property (!take |=> !mem_ack && $stable(mem_rdata))
		else $error("refused access answered");
	status_read_a: assert property (take && !mem_wr && mem_addr == ADDR_STATUS
		|=> mem_rdata == {6'h00, $past(cipher_busy), $past(cipher_done)})
		else $error("status byte wrong");
	run_start_a: assert property (go |=> cipher_busy && !cipher_done)
		else $error("request did not start a run");
	run_bound_a: assert property (run_q <= AES_ROUNDS + 4'h1)
		else $error("run too long");
	done_timing_a: assert property ($rose(cipher_done)
		|-> run_q == AES_ROUNDS + 4'h1)
		else $error("done without a full run");
	ctrl_abort_a: assert property (cipher_busy && ctl |=> !cipher_busy && !cipher_done)
		else $error("control access did not abort");
	mirror_keeps_a: assert property (cipher_busy && take
		&& mem_addr == ADDR_CTRL_COPY && run_q < 4'h9 |=> cipher_busy)
		else $error("mirror access stopped the run");
	power_clear_a: assert property (deepest_power_down || trx_reset_state
		|=> !cipher_busy && !cipher_done)
		else $error("power state did not clear the engine");
endmodule : aes128_cipher_chk

bind aes128_block_cipher_control aes128_cipher_chk #(.PAGE_BYTES(PAGE_BYTES))
	u_aes128_cipher_chk (.clk(clk), .sys_rst(sys_rst), .trx_sleep(trx_sleep),
	.deepest_power_down(deepest_power_down), .trx_reset_state(trx_reset_state),
	.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
	.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.cipher_busy(cipher_busy), .cipher_done(cipher_done));
`default_nettype wire

// ===== testbench/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: issues one byte access per cycle, changing at falling edges.
module spi_host
	import aes_cipher_pkg::*;
(
	input  wire logic       clk,
	output logic [7:0]      mem_addr,
	output logic            mem_wr,
	output logic            mem_rd,
	output logic [7:0]      mem_wdata,
	input  wire logic [7:0] mem_rdata,
	input  wire logic       mem_ack
);
	int miss = 0; // Accesses that should have been answered but were not.

	initial
	begin
		mem_addr = 8'h00;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_wdata = 8'h00;
	end

	// One access; strobes stay up so a caller may chain the next one.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic k);
		mem_wr = w;
		mem_rd = !w;
		mem_addr = a;
		mem_wdata = d;
		@(negedge clk);
		q = mem_rdata;
		k = mem_ack;
	endtask : acc

	// Released lines show the inverse, so stale values never look valid.
	task automatic idle();
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_addr = ~mem_addr;
		mem_wdata = ~mem_wdata;
		@(negedge clk);
	endtask : idle

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic k;
		acc(w, a, d, q, k);
		if (k !== 1'b1)
			miss++;
	endtask : xfer

	// Control byte, sixteen page bytes, optional start from the mirror.
	task automatic burst(input logic [7:0] cfg, input logic [127:0] blk,
		input logic go, output logic [127:0] old);
		logic [7:0] q;
		xfer(1'b1, ADDR_CTRL, cfg, q);
		for (int i = 0; i < 16; i++)
		begin
			xfer(1'b1, ADDR_PAGE_FIRST + 8'(i), blk[127-8*i -: 8], q);
			old[127-8*i -: 8] = q;
		end
		if (go)
			xfer(1'b1, ADDR_CTRL_COPY, cfg | 8'h80, q);
		idle();
	endtask : burst

	task automatic rdpage(output logic [127:0] v);
		logic [7:0] q;
		for (int i = 0; i < 16; i++)
		begin
			xfer(1'b0, ADDR_PAGE_FIRST + 8'(i), 8'h00, q);
			v[127-8*i -: 8] = q;
		end
		idle();
	endtask : rdpage
endmodule : spi_host
`default_nettype wire

// ===== testbench/aes128_block_cipher_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aes128_block_cipher_control_tb
	import aes_cipher_pkg::*;
;
	// Published single-block test vector and its tenth round key.
	localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] RK  = 128'h13111D7FE3944A17F307A78B4D2B30C5;
	logic         clk, sys_rst, trx_sleep, deepest_power_down, trx_reset_state;
	logic [7:0]   mem_addr, mem_wdata, mem_rdata, q;
	logic         mem_wr, mem_rd, mem_ack, cipher_busy, cipher_done, k;
	logic [127:0] v;
	int           errors = 0, n_tests = 0, cycles = 0;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	aes128_block_cipher_control u_aes128_block_cipher_control (.clk(clk),
		.sys_rst(sys_rst), .trx_sleep(trx_sleep),
		.deepest_power_down(deepest_power_down),
		.trx_reset_state(trx_reset_state), .mem_addr(mem_addr),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.cipher_busy(cipher_busy), .cipher_done(cipher_done));
	spi_host u_spi_host (.clk(clk), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));

	task automatic chk(input string s, input logic [127:0] e, input logic [127:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Bounded wait; a run takes eleven cycles.
	task automatic wait_done();
		for (int i = 0; i < 40 && cipher_done !== 1'b1; i++)
			@(negedge clk);
	endtask : wait_done

	// The whole test takes far fewer cycles than this ceiling.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			$display("[ERR] cycles expected below 5000 seen %0d", cycles);
			wrap_up();
		end
	end

	initial
	begin
		sys_rst = 1'b1;
		trx_sleep = 1'b0;
		deepest_power_down = 1'b0;
		trx_reset_state = 1'b0;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		u_spi_host.burst(8'h10, KEY, 1'b0, v);
		u_spi_host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
		chk("status", 0, q);
		u_spi_host.burst(8'h00, PT, 1'b1, v);
		wait_done();
		chk("done", 1, cipher_done);
		u_spi_host.rdpage(v);
		chk("ecb", CT, v);
		u_spi_host.xfer(1'b1, ADDR_CTRL, 8'h10, q);
		u_spi_host.rdpage(v);
		chk("last_key", RK, v);
		$display("test ecb finished");
		// Second run with the stored key; fast mode returns the last result.
		u_spi_host.burst(8'h00, PT, 1'b1, v);
		chk("fast_old", CT, v);
		wait_done();
		u_spi_host.rdpage(v);
		chk("ecb_again", CT, v);
		u_spi_host.burst(8'h20, CT ^ PT, 1'b1, v);
		wait_done();
		u_spi_host.rdpage(v);
		chk("cbc", CT, v);
		$display("test chain finished");
		u_spi_host.burst(8'h10, RK, 1'b0, v);
		u_spi_host.burst(8'h08, CT, 1'b1, v);
		wait_done();
		u_spi_host.rdpage(v);
		chk("decrypt", PT, v);
		$display("test decrypt finished");
		// Start from the control byte, touch the mirror, then abort.
		u_spi_host.xfer(1'b1, ADDR_CTRL, 8'h80, q);
		chk("start_busy", 1, cipher_busy);
		u_spi_host.xfer(1'b1, ADDR_CTRL_COPY, 8'h00, q);
		chk("mirror_busy", 1, cipher_busy);
		u_spi_host.xfer(1'b0, ADDR_CTRL, 8'h00, q);
		u_spi_host.idle();
		chk("abort", 0, {cipher_busy, cipher_done});
		$display("test abort finished");
		trx_sleep = 1'b1;
		u_spi_host.acc(1'b0, ADDR_STATUS, 8'h00, q, k);
		chk("sleep_ack", 0, k);
		trx_sleep = 1'b0;
		u_spi_host.acc(1'b0, 8'h81, 8'h00, q, k);
		chk("window_ack", 0, k);
		deepest_power_down = 1'b1;
		u_spi_host.idle();
		deepest_power_down = 1'b0;
		u_spi_host.rdpage(v);
		chk("clr_data", 0, v);
		u_spi_host.xfer(1'b1, ADDR_CTRL, 8'h10, q);
		chk("clr_ctrl", 0, q);
		u_spi_host.rdpage(v);
		chk("clr_key", 0, v);
		u_spi_host.burst(8'h00, PT, 1'b1, v);
		trx_reset_state = 1'b1;
		u_spi_host.idle();
		trx_reset_state = 1'b0;
		chk("reset_stop", 0, {cipher_busy, cipher_done});
		chk("acks", 0, u_spi_host.miss);
		$display("test power finished");
		wrap_up();
	end
endmodule : aes128_block_cipher_control_tb
`default_nettype wire
